// ### src/capture_field1_map.svh
`ifndef CAPTURE_FIELD1_MAP_SVH
`define CAPTURE_FIELD1_MAP_SVH
// register byte offsets
`define OFS_START 4'h0
`define OFS_STOP 4'h4
`define OFS_CTRL 4'h8
`define OFS_STATUS 4'hC
// start, stop and counter field layout
`define HI_MSB 27
`define HI_LSB 16
`define LO_MSB 11
`define LO_LSB 0
`define CNT_HI_MSB 23
`define CNT_HI_LSB 12
`define SSE_BIT 15
// write masks keep reserved bits at zero
`define START_MASK 32'h0FFF_8FFF
`define STOP_MASK 32'h0FFF_0FFF
`define CTRL_MASK 32'h0000_003F
// control layout
`define CTL_MODE_MSB 1
`define CTL_MODE_LSB 0
`define CTL_F1EN 2
`define CTL_CHEN 3
`define CTL_HSEL 4
`define CTL_VSEL 5
// status layout
`define ST_FRAME_COMPLETE_FLAG 0
`define ST_ACT 1
`define ST_BLANK 2
`define ST_SYNCW 3
// constants
`define RST_WORD 32'h0000_0000
`define PIX_RESET 12'h000
`define LINE_RESET 12'h001
`define CNT_ONE 24'h00_0001
`define IDLE_ZERO 12'h000
`define IDLE_MAX 12'hFFF
`define TS_SYNC_BYTE 8'h47
`define INTERVALS_NEEDED 2'h2
`define INTERVAL_ZERO 2'h0
`endif

// ### src/capture_field1_pkg.sv
package capture_field1_pkg;
  // capture mode held in the control register
  typedef enum logic [1:0] {
    MODE_VIDEO,
    MODE_RAW,
    MODE_TS
  } mode_t;
  // capture sequencing
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_SYNC,
    ST_CAPTURE
  } state_t;
endpackage : capture_field1_pkg

// ### src/capture_field1_window.sv
`timescale 1ns/1ps
`include "capture_field1_map.svh"
module capture_field1_window #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // link pins, all asynchronous to sys_clk_in
  input wire logic link_clk_in,
  input wire logic capture_enable_input_in,
  input wire logic h_event_a_in,
  input wire logic h_event_b_in,
  input wire logic v_event_a_in,
  input wire logic v_event_b_in,
  input wire logic [DATA_W-1:0] link_data_in,
  // capture results
  output logic capture_active_out,
  output logic sample_valid_out,
  output logic [DATA_W-1:0] sample_data_out,
  output logic [11:0] pixel_counter_out,
  output logic [11:0] line_counter_out,
  output logic frame_complete_flag_out,
  output logic blanking_out
);
  localparam int IN_W = DATA_W + 6;

  // keep the lsb of a pixel field at zero
  function automatic logic [11:0] even12(input logic [11:0] v);
    even12 = {v[11:1], 1'b0};
  endfunction : even12

  // registers
  logic [31:0] start_r; // field1_capture_start
  logic [31:0] stop_r; // field1_capture_stop
  logic [31:0] ctrl_r; // channel_control_register bits
  logic frame_complete_flag_r; // frame_complete_flag
  logic [31:0] rdata_r; // read data, one cycle late
  // synchroniser, stage one read only by stage two
  logic [IN_W-1:0] sync1_r;
  logic [IN_W-1:0] sync2_r;
  logic lclk_prev_r; // for link clock edge
  logic chen_prev_r; // for enable rise
  // capture state
  capture_field1_pkg::state_t state_r, state_nxt;
  logic [23:0] cnt_r, cnt_nxt; // pixel low, line high
  logic [11:0] idle_r, idle_nxt; // link ticks with enable low
  logic [1:0] intv_r, intv_nxt; // blanking intervals seen
  logic valid_r;
  logic [DATA_W-1:0] data_r;
  logic frame_complete_flag_set; // packet complete event

  // synchronised pins
  wire lclk = sync2_r[IN_W-1];
  wire capture_enable_input = sync2_r[IN_W-2];
  wire ha = sync2_r[IN_W-3];
  wire hb = sync2_r[IN_W-4];
  wire va = sync2_r[IN_W-5];
  wire vb = sync2_r[IN_W-6];
  wire [DATA_W-1:0] din = sync2_r[DATA_W-1:0];
  // samples are taken on the link clock rising edge; data was
  // launched half a link period earlier, so it is settled here
  wire tick = lclk & ~lclk_prev_r;

  // control decode
  wire [1:0] mode_bits = ctrl_r[`CTL_MODE_MSB:`CTL_MODE_LSB];
  wire f1_en = ctrl_r[`CTL_F1EN];
  wire ch_en = ctrl_r[`CTL_CHEN];
  wire ch_rise = ch_en & ~chen_prev_r;
  // selected horizontal and vertical events
  wire hev = ctrl_r[`CTL_HSEL] ? hb : ha;
  wire vev = ctrl_r[`CTL_VSEL] ? vb : va;
  wire is_video = mode_bits == capture_field1_pkg::MODE_VIDEO;
  wire is_raw = mode_bits == capture_field1_pkg::MODE_RAW;
  wire is_ts = mode_bits == capture_field1_pkg::MODE_TS;

  // register fields
  wire [11:0] start_px = even12(start_r[`LO_MSB:`LO_LSB]);
  wire [11:0] start_ln = start_r[`HI_MSB:`HI_LSB];
  wire [11:0] min_blank = start_r[`LO_MSB:`LO_LSB];
  wire startup_sync_enable = start_r[`SSE_BIT] & is_raw;
  wire [11:0] stop_px = even12(stop_r[`LO_MSB:`LO_LSB]);
  wire [11:0] stop_ln = stop_r[`HI_MSB:`HI_LSB];
  wire [23:0] data_size = {stop_ln, stop_r[`LO_MSB:`LO_LSB]};

  // counter views, one register serves all modes
  wire [11:0] px = cnt_r[`LO_MSB:`LO_LSB];
  wire [11:0] ln = cnt_r[`CNT_HI_MSB:`CNT_HI_LSB];
  wire [23:0] cnt_inc = cnt_r + `CNT_ONE;

  // video start and stop, positions count raw samples so
  // they hold whatever scaling is applied downstream
  wire vid_start = f1_en & ch_en & (px == start_px) & (ln == start_ln);
  wire vid_end = (ln == stop_ln) & (px == stop_px);
  wire in_cols = (px >= start_px) & (px < stop_px);
  wire in_lines = (ln >= start_ln) & (ln <= stop_ln);

  // raw blanking detection
  wire blank_lvl = idle_r > min_blank;
  wire blank_evt = tick & ~capture_enable_input & (idle_r == min_blank);
  wire raw_start = f1_en & ch_en & capture_enable_input;
  // ts start ignores the start register entirely
  wire ts_start = ch_en & capture_enable_input & ~frame_complete_flag_r & (din == `TS_SYNC_BYTE);
  wire size_hit = cnt_inc == data_size;

  // register read decode
  wire sel_start = reg_addr_in == `OFS_START;
  wire sel_stop = reg_addr_in == `OFS_STOP;
  wire sel_ctrl = reg_addr_in == `OFS_CTRL;
  wire sel_stat = reg_addr_in == `OFS_STATUS;
  wire [31:0] status_word = {28'h000_0000,
    state_r == capture_field1_pkg::ST_WAIT_SYNC, blank_lvl,
    state_r == capture_field1_pkg::ST_CAPTURE, frame_complete_flag_r};
  wire [31:0] rd_mux = sel_start ? start_r :
    sel_stop ? stop_r :
    sel_ctrl ? ctrl_r :
    sel_stat ? status_word : `RST_WORD;
  // write-one-to-clear, but a packet end in the same cycle wins
  wire frame_complete_flag_clr = reg_wr_in & sel_stat & reg_wdata_in[`ST_FRAME_COMPLETE_FLAG];

  // blanking idle counter, saturating so long gaps stay blank
  always_comb begin
    idle_nxt = idle_r;
    if (capture_enable_input) begin
      idle_nxt = `IDLE_ZERO;
    end else if (tick && idle_r != `IDLE_MAX) begin
      idle_nxt = idle_r + 12'h001;
    end
  end

  // capture sequencing per mode
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    intv_nxt = intv_r;
    frame_complete_flag_set = 1'b0;
    unique case (mode_bits)
      capture_field1_pkg::MODE_VIDEO: begin
        // free running pixel and line counters
        if (tick) begin
          if (hev) begin
            cnt_nxt[`LO_MSB:`LO_LSB] = `PIX_RESET;
            cnt_nxt[`CNT_HI_MSB:`CNT_HI_LSB] = ln + 12'h001;
          end else begin
            cnt_nxt[`LO_MSB:`LO_LSB] = px + 12'h001;
          end
          if (vev) begin
            cnt_nxt[`CNT_HI_MSB:`CNT_HI_LSB] = `LINE_RESET;
          end
        end
        unique case (state_r)
          capture_field1_pkg::ST_CAPTURE: begin
            // window closes after the last pixel of the last line
            // disabling aborts at once, not at the next link tick
            if ((tick && vid_end) || !f1_en || !ch_en) begin
              state_nxt = capture_field1_pkg::ST_IDLE;
            end
          end
          default: begin
            // startup sync has no meaning here
            if (tick && vid_start) begin
              state_nxt = capture_field1_pkg::ST_CAPTURE;
            end
          end
        endcase
      end
      capture_field1_pkg::MODE_RAW: begin
        unique case (state_r)
          capture_field1_pkg::ST_WAIT_SYNC: begin
            // top of frame found after two blanking gaps
            if (blank_evt) begin
              intv_nxt = intv_r + 2'h1;
            end
            if (intv_r == `INTERVALS_NEEDED) begin
              state_nxt = capture_field1_pkg::ST_IDLE;
            end
            if (!ch_en) begin
              state_nxt = capture_field1_pkg::ST_IDLE;
            end
          end
          capture_field1_pkg::ST_CAPTURE: begin
            // one merged counter of samples
            if (tick && capture_enable_input) begin
              cnt_nxt = cnt_inc;
              if (size_hit) begin
                state_nxt = capture_field1_pkg::ST_IDLE;
              end
            end
            if (!ch_en) begin
              state_nxt = capture_field1_pkg::ST_IDLE;
            end
          end
          default: begin
            if (ch_rise && startup_sync_enable) begin
              state_nxt = capture_field1_pkg::ST_WAIT_SYNC;
              intv_nxt = `INTERVAL_ZERO;
            end else if (tick && raw_start) begin
              state_nxt = capture_field1_pkg::ST_CAPTURE;
              cnt_nxt = `CNT_ONE;
            end
          end
        endcase
      end
      capture_field1_pkg::MODE_TS: begin
        unique case (state_r)
          capture_field1_pkg::ST_CAPTURE: begin
            // byte counter after the sync byte
            if (tick && capture_enable_input) begin
              cnt_nxt = cnt_inc;
              if (size_hit) begin
                frame_complete_flag_set = 1'b1;
                state_nxt = capture_field1_pkg::ST_IDLE;
              end
            end
            if (!ch_en) begin
              state_nxt = capture_field1_pkg::ST_IDLE;
            end
          end
          default: begin
            if (tick && ts_start) begin
              state_nxt = capture_field1_pkg::ST_CAPTURE;
              cnt_nxt = `CNT_ONE;
            end
          end
        endcase
      end
      default: begin
        // illegal mode code parks the channel
        state_nxt = capture_field1_pkg::ST_IDLE;
      end
    endcase
  end

  // pin synchroniser and edge history
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      lclk_prev_r <= 1'b0;
      chen_prev_r <= 1'b0;
    end else begin
      sync1_r <= {link_clk_in, capture_enable_input_in, h_event_a_in,
        h_event_b_in, v_event_a_in, v_event_b_in, link_data_in};
      sync2_r <= sync1_r;
      lclk_prev_r <= lclk;
      chen_prev_r <= ch_en;
    end
  end

  // software registers, reserved bits masked off on write
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_r <= `RST_WORD;
      stop_r <= `RST_WORD;
      ctrl_r <= `RST_WORD;
    end else if (reg_wr_in) begin
      if (sel_start) begin
        start_r <= reg_wdata_in & `START_MASK;
      end
      if (sel_stop) begin
        stop_r <= reg_wdata_in & `STOP_MASK;
      end
      if (sel_ctrl) begin
        ctrl_r <= reg_wdata_in & `CTRL_MASK;
      end
    end
  end

  // frame complete flag, set beats clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_complete_flag_r <= 1'b0;
    end else begin
      frame_complete_flag_r <= frame_complete_flag_set | (frame_complete_flag_r & ~frame_complete_flag_clr);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= `RST_WORD;
    end else begin
      rdata_r <= reg_rd_in ? rd_mux : `RST_WORD;
    end
  end

  // capture state registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= capture_field1_pkg::ST_IDLE;
      cnt_r <= '0;
      idle_r <= `IDLE_ZERO;
      intv_r <= `INTERVAL_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      idle_r <= idle_nxt;
      intv_r <= intv_nxt;
    end
  end

  // video takes samples inside the window only
  wire vid_take = (state_r == capture_field1_pkg::ST_CAPTURE) & in_cols & in_lines;
  // block modes count the starting sample, so it must be output too
  wire blk_take = capture_enable_input & ((state_r == capture_field1_pkg::ST_CAPTURE) |
    (state_nxt == capture_field1_pkg::ST_CAPTURE));
  // captured sample output, one per link tick inside the window
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      valid_r <= 1'b0;
      data_r <= '0;
    end else begin
      valid_r <= tick & (is_video ? vid_take : blk_take);
      if (tick) begin
        data_r <= din;
      end
    end
  end

  // outputs
  assign reg_rdata_out = rdata_r;
  assign capture_active_out = state_r == capture_field1_pkg::ST_CAPTURE;
  assign sample_valid_out = valid_r;
  assign sample_data_out = data_r;
  assign pixel_counter_out = px;
  assign line_counter_out = ln;
  assign frame_complete_flag_out = frame_complete_flag_r;
  assign blanking_out = blank_lvl & is_raw;
endmodule : capture_field1_window

// ### verif/capture_field1_window_chk.sv
`timescale 1ns/1ps
`include "capture_field1_map.svh"
module capture_field1_window_chk #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // link pins
  input wire logic link_clk_in,
  input wire logic capture_enable_input_in,
  input wire logic h_event_a_in,
  input wire logic h_event_b_in,
  input wire logic v_event_a_in,
  input wire logic v_event_b_in,
  input wire logic [DATA_W-1:0] link_data_in,
  // capture results
  input wire logic capture_active_out,
  input wire logic sample_valid_out,
  input wire logic [DATA_W-1:0] sample_data_out,
  input wire logic [11:0] pixel_counter_out,
  input wire logic [11:0] line_counter_out,
  input wire logic frame_complete_flag_out,
  input wire logic blanking_out
);
  // shadow of what software wrote
  logic [31:0] start_r;
  logic [31:0] stop_r;
  logic [5:0] ctrl_r;
  // merged counter and size, as raw and stream modes see them
  wire logic [23:0] cnt = {line_counter_out, pixel_counter_out};
  wire logic [23:0] size = {stop_r[27:16], stop_r[11:0]};
  wire logic [1:0] mode = ctrl_r[1:0];
  // follow writes on the same edge the block takes them
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_r <= '0;
      stop_r <= '0;
      ctrl_r <= '0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `OFS_START) start_r <= reg_wdata_in;
      if (reg_addr_in == `OFS_STOP) stop_r <= reg_wdata_in;
      if (reg_addr_in == `OFS_CTRL) ctrl_r <= reg_wdata_in[5:0];
    end
  end
  // one domain only
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  read_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  start_resv_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == `OFS_START
    |-> (reg_rdata_out & 32'hF000_7000) == 32'h0) else $error("start reserved bits not zero");
  stop_resv_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == `OFS_STOP
    |-> (reg_rdata_out & 32'hF000_F000) == 32'h0) else $error("stop reserved bits not zero");
  valid_pulse_a: assert property (sample_valid_out |=> (!sample_valid_out) [*4])
    else $error("sample pulse too long");
  count_step_a: assert property ($past(capture_active_out) && cnt != $past(cnt)
    && mode != capture_field1_pkg::MODE_VIDEO |-> cnt == $past(cnt) + 24'h00_0001)
    else $error("merged counter did not step by one");
  stop_size_a: assert property ($rose(cnt == size) && mode != capture_field1_pkg::MODE_VIDEO
    |=> !capture_active_out) else $error("capture ran past data size");
  ts_flag_a: assert property ($rose(cnt == size) && mode == capture_field1_pkg::MODE_TS
    |-> ##[0:2] frame_complete_flag_out) else $error("packet end without frame flag");
  ts_start_a: assert property ($rose(capture_active_out) && mode == capture_field1_pkg::MODE_TS
    |-> !$past(frame_complete_flag_out) ##1 sample_data_out[7:0] == `TS_SYNC_BYTE)
    else $error("stream capture started wrongly");
  video_start_a: assert property ($rose(capture_active_out) && mode == capture_field1_pkg::MODE_VIDEO
    |-> $past(pixel_counter_out) == {start_r[11:1], 1'b0} && $past(line_counter_out) == start_r[27:16])
    else $error("video capture started off window");
  field_gate_a: assert property ($rose(capture_active_out) && mode != capture_field1_pkg::MODE_TS
    |-> ctrl_r[2] && ctrl_r[3]) else $error("capture started without field enable");
  // main scenarios reached
  cover property ($rose(capture_active_out) && mode == capture_field1_pkg::MODE_TS);
  cover property ($rose(capture_active_out) && mode == capture_field1_pkg::MODE_RAW);
  cover property ($rose(blanking_out));
endmodule : capture_field1_window_chk
bind capture_field1_window capture_field1_window_chk #(.DATA_W(DATA_W)) u_chk (
  .sys_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .link_clk_in, .capture_enable_input_in, .h_event_a_in, .h_event_b_in, .v_event_a_in,
  .v_event_b_in, .link_data_in, .capture_active_out, .sample_valid_out, .sample_data_out,
  .pixel_counter_out, .line_counter_out, .frame_complete_flag_out, .blanking_out
);

// ### verif/link_source_model.sv
`timescale 1ns/1ps
module link_source_model (
  // link clock, still between samples
  output logic link_clk_out,
  // qualifier, events and data
  output logic capture_enable_input_out,
  output logic [3:0] event_out,
  output logic [7:0] data_out
);
  // quiet link at time zero
  initial begin
    link_clk_out = 1'b0;
    capture_enable_input_out = 1'b0;
    event_out = 4'h0;
    data_out = 8'h00;
  end
  // one sample: set up while low, rise mid-period, 400 ns in all
  // every change kept off the system clock edges to avoid races
  task automatic tick(input logic [7:0] d, input logic en, input logic [3:0] e);
    #7;
    data_out = d;
    capture_enable_input_out = en;
    event_out = e;
    #190;
    link_clk_out = 1'b1;
    #200;
    link_clk_out = 1'b0;
    // released data must not look held
    data_out = ~d;
    event_out = 4'h0;
    #3;
  endtask : tick
endmodule : link_source_model

// ### verif/tb.sv
`timescale 1ns/1ps
`include "capture_field1_map.svh"
module tb;
  // clock, reset and register port
  logic sys_clk_in, reset_n_in, reg_wr_in, reg_rd_in;
  logic [3:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  // link side and results
  logic link_clk, capture_enable_input, active, valid, flag, blank;
  logic [3:0] ev;
  logic [7:0] ldata, sdata;
  logic [11:0] pix, line;
  // tallies for the verdict
  int fails, n_tests;
  // sample pulses seen, tallied on their own
  int n_valid = 0;
  // block under test
  capture_field1_window #(.DATA_W(8)) dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .link_clk_in(link_clk), .capture_enable_input_in(capture_enable_input),
    .h_event_a_in(ev[3]), .h_event_b_in(ev[2]), .v_event_a_in(ev[1]), .v_event_b_in(ev[0]),
    .link_data_in(ldata), .capture_active_out(active), .sample_valid_out(valid),
    .sample_data_out(sdata), .pixel_counter_out(pix), .line_counter_out(line),
    .frame_complete_flag_out(flag), .blanking_out(blank)
  );
  // far-side source
  link_source_model src (.link_clk_out(link_clk), .capture_enable_input_out(capture_enable_input), .event_out(ev), .data_out(ldata));
  // count one-cycle sample pulses as they pass
  always @(posedge sys_clk_in) begin
    if (valid === 1'b1) begin
      n_valid <= n_valid + 1;
    end
  end
  // verdict and end of run
  task automatic conclude();
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // one comparison
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic ckb(input string w, input logic e, input logic g);
    chk(w, {31'h0, e}, {31'h0, g});
  endtask : ckb
  task automatic ckn(input string w, input logic [11:0] e, input logic [11:0] g);
    chk(w, {20'h0, e}, {20'h0, g});
  endtask : ckn
  // single-cycle write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  // read, data stands only in the next cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("read data", e, reg_rdata_out);
  endtask : rd
  // one link sample, then let the sync chain settle
  task automatic tk(input logic [7:0] d, input logic en, input logic [3:0] e);
    src.tick(d, en, e);
    @(posedge sys_clk_in);
    #1;
  endtask : tk
  // stop reset value, reserved bits, unmapped place
  task automatic t_regs();
    rd(`OFS_STOP, 32'h0000_0000);
    wr(`OFS_START, 32'hFFFF_FFFF);
    wr(`OFS_STOP, 32'hFFFF_FFFF);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(`OFS_START, 32'h0FFF_8FFF);
    rd(`OFS_STOP, 32'h0FFF_0FFF);
    rd(4'h2, 32'h0000_0000);
  endtask : t_regs
  // video window, odd start pixel, selected events only
  task automatic t_video();
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_START, 32'h0002_0003);
    wr(`OFS_STOP, 32'h0005_0010);
    wr(`OFS_CTRL, 32'h0000_003C);
    tk(8'h10, 1'b1, 4'b0001);
    ckn("line", 12'h001, line);
    tk(8'h11, 1'b1, 4'b0110);
    ckn("pixel", 12'h000, pix);
    ckn("line", 12'h002, line);
    tk(8'h12, 1'b1, 4'b1000);
    ckn("pixel", 12'h001, pix);
    ckb("active", 1'b0, active);
    tk(8'h13, 1'b1, 4'b0000);
    ckb("active", 1'b0, active);
    tk(8'h14, 1'b1, 4'b0000);
    ckb("active", 1'b1, active);
    chk("sample data", 32'h0000_0014, {24'h00_0000, sdata});
  endtask : t_video
  // stream packets, sync byte, frame flag
  task automatic t_ts();
    int v0;
    v0 = n_valid;
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_START, 32'hFFFF_FFFF);
    wr(`OFS_STOP, 32'h0000_0003);
    wr(`OFS_CTRL, 32'h0000_000A);
    tk(8'h12, 1'b1, 4'h0);
    tk(8'h47, 1'b0, 4'h0);
    ckb("active", 1'b0, active);
    tk(8'h47, 1'b1, 4'h0);
    ckb("active", 1'b1, active);
    tk(8'h47, 1'b1, 4'h0);
    tk(8'h55, 1'b1, 4'h0);
    ckn("pixel", 12'h003, pix);
    ckb("active", 1'b0, active);
    ckb("flag", 1'b1, flag);
    chk("valid pulses", 32'h0000_0003, n_valid - v0);
    chk("sample data", 32'h0000_0055, {24'h00_0000, sdata});
    tk(8'h47, 1'b1, 4'h0);
    ckb("active", 1'b0, active);
    wr(`OFS_STATUS, 32'h0000_0001);
    tk(8'h47, 1'b1, 4'h0);
    ckb("active", 1'b1, active);
  endtask : t_ts
  // raw block held off by startup sync
  task automatic t_raw();
    int v0;
    v0 = n_valid;
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_STOP, 32'h0000_0004);
    wr(`OFS_START, 32'h0000_8002);
    wr(`OFS_CTRL, 32'h0000_000D);
    tk(8'h21, 1'b1, 4'h0);
    tk(8'h00, 1'b0, 4'h0);
    tk(8'h00, 1'b0, 4'h0);
    ckb("blanking", 1'b0, blank);
    tk(8'h00, 1'b0, 4'h0);
    ckb("blanking", 1'b1, blank);
    tk(8'h22, 1'b1, 4'h0);
    ckb("active", 1'b0, active);
    repeat (3) tk(8'h00, 1'b0, 4'h0);
    tk(8'h23, 1'b1, 4'h0);
    ckb("active", 1'b1, active);
    repeat (3) tk(8'h24, 1'b1, 4'h0);
    ckn("pixel", 12'h004, pix);
    chk("valid pulses", 32'h0000_0004, n_valid - v0);
    chk("sample data", 32'h0000_0024, {24'h00_0000, sdata});
    ckb("active", 1'b0, active);
  endtask : t_raw
  // free-running system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // guard against a hang
  initial begin
    #2_000_000;
    fails++;
    conclude();
  end
  // main sequence
  initial begin
    reset_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 32'h0000_0000;
    fails = 0;
    n_tests = 0;
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_video();
    t_ts();
    t_raw();
    conclude();
  end
endmodule : tb
